// File: rrs_air_model.sv
// Far-side transmitter model that delivers reception results and rate reports.
`timescale 1ns/100ps
`default_nettype none
module rrs_air_model (
  // Clock
  input wire logic pclk,
  // Reception reports
  output var rrs_pkg::rrs_rx_res_t rx_res,
  output var rrs_pkg::rrs_ci_t ci_rpt
);
  initial begin
    rx_res = '0;
    ci_rpt = '0;
  end
  // Fields are only valid with the strobe, so they are scrambled afterwards.
  task automatic send(input rrs_pkg::rrs_rx_res_t r);
    @(posedge pclk);
    rx_res <= r;
    @(posedge pclk);
    rx_res <= {1'h0, ~r[41:0]};
  endtask
  task automatic boost(input logic lr, input logic r5);
    @(posedge pclk);
    ci_rpt <= {1'h1, lr, r5};
    @(posedge pclk);
    ci_rpt <= {1'h0, ~lr, ~r5};
  endtask
endmodule
`default_nettype wire

// File: rrs_map.svh
// Register offsets, field positions and reset values of the receive status slice.
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RRS_IRQ_ENABLE_OFS 12'h304
`define RRS_IRQ_DISABLE_OFS 12'h308
`define RRS_CRC_STATUS_OFS 12'h400
`define RRS_RX_LADDR_OFS 12'h408
`define RRS_RX_CRC_OFS 12'h40C
`define RRS_DAI_OFS 12'h410
`define RRS_PAYLOAD_OFS 12'h414
`define RRS_MAXLEN_OFS 12'h518

// ----------------------------------------------------------------------------
// Interrupt enable bit positions
// ----------------------------------------------------------------------------
`define RRS_BIT_RATE_SWITCH 20
`define RRS_BIT_TX_READY 21
`define RRS_BIT_RX_READY 22
`define RRS_BIT_HDR_MATCH 23
`define RRS_BIT_PHY_END 27
`define RRS_BIT_TONE_EXT 28
`define RRS_IRQ_MASK 32'h18F00000

// ----------------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------------
`define RRS_LADDR_W 3
`define RRS_CRC_W 24
`define RRS_DAI_W 3
`define RRS_LEN_W 8
`define RRS_PAYLOAD_BIT 0
`define RRS_RATE_LSB 1
`define RRS_RATE_W 2
`define RRS_RATE_125K 2'h0
`define RRS_RATE_500K 2'h1
`define RRS_RESET_WORD 32'h00000000
`define RRS_MAXLEN_RESET 8'hFF

`endif

// File: rrs_pkg.sv
// Types shared by the receive status slice.
`default_nettype none

package rrs_pkg;

  // --------------------------------------------------------------------------
  // Result of one completed reception
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic done;
    logic crc_ok;
    logic [2:0] laddr;
    logic [23:0] crc;
    logic dev_match;
    logic [2:0] dev_idx;
    logic [7:0] length;
    logic long_range;
    logic rate_500k;
  } rrs_rx_res_t;

  // --------------------------------------------------------------------------
  // Coding indicator report
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic long_range;
    logic rate_500k;
  } rrs_ci_t;

  // --------------------------------------------------------------------------
  // Whole state of the slice
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] irq_en;
    logic [7:0] maxlen;
    logic crc_ok;
    logic [2:0] laddr;
    logic [23:0] crc;
    logic [2:0] address_match_index;
    logic len_over;
    logic [1:0] rate;
    logic rate_evt;
    logic [31:0] prdata;
    logic pslverr;
  } rrs_state_t;

endpackage

`default_nettype wire

// File: rrs_regs.sv
// Receive status registers and interrupt enable slice of the radio.
`include "rrs_map.svh"
`timescale 1ns/100ps
`default_nettype none

module rrs_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive core
  input wire rrs_pkg::rrs_rx_res_t rx_res,
  input wire rrs_pkg::rrs_ci_t ci_rpt,
  // Event and control outputs
  output logic rate_switch_event,
  output logic [31:0] irq_enable,
  output logic [7:0] max_payload_length
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic addr_known(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      `RRS_IRQ_ENABLE_OFS,
      `RRS_IRQ_DISABLE_OFS,
      `RRS_CRC_STATUS_OFS,
      `RRS_RX_LADDR_OFS,
      `RRS_RX_CRC_OFS,
      `RRS_DAI_OFS,
      `RRS_PAYLOAD_OFS,
      `RRS_MAXLEN_OFS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  function automatic logic is_status(input logic [11:0] a);
    logic hit;
    hit = (a == `RRS_CRC_STATUS_OFS) || (a == `RRS_RX_LADDR_OFS) ||
          (a == `RRS_RX_CRC_OFS) || (a == `RRS_DAI_OFS) ||
          (a == `RRS_PAYLOAD_OFS);
    return hit;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rrs_pkg::rrs_state_t st_ff;
  rrs_pkg::rrs_state_t nxt_st;

  logic setup_ph;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_word;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // Byte lanes of the write data that the master marks valid.
  always_comb begin
    wmask = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{pstrb[i]}};
    end
    wbits = pwdata & wmask;
  end

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always_comb begin
    rd_word = `RRS_RESET_WORD;
    unique case (paddr)
      `RRS_IRQ_ENABLE_OFS,
      `RRS_IRQ_DISABLE_OFS: begin
        rd_word = st_ff.irq_en;
      end
      `RRS_CRC_STATUS_OFS: begin
        rd_word[0] = st_ff.crc_ok;
      end
      `RRS_RX_LADDR_OFS: begin
        rd_word[`RRS_LADDR_W-1:0] = st_ff.laddr;
      end
      `RRS_RX_CRC_OFS: begin
        rd_word[`RRS_CRC_W-1:0] = st_ff.crc;
      end
      `RRS_DAI_OFS: begin
        rd_word[`RRS_DAI_W-1:0] = st_ff.address_match_index;
      end
      `RRS_PAYLOAD_OFS: begin
        rd_word[`RRS_PAYLOAD_BIT] = st_ff.len_over;
        rd_word[`RRS_RATE_LSB +: `RRS_RATE_W] = st_ff.rate;
      end
      `RRS_MAXLEN_OFS: begin
        rd_word[`RRS_LEN_W-1:0] = st_ff.maxlen;
      end
      default: begin
        rd_word = `RRS_RESET_WORD;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rate_evt = 1'b0;

    // Read data and error are prepared in the setup phase.
    if (setup_ph) begin
      nxt_st.prdata = pwrite ? `RRS_RESET_WORD : rd_word;
      nxt_st.pslverr = !addr_known(paddr) || (pwrite && is_status(paddr));
    end

    // Register writes take effect at the access edge.
    if (wr_acc) begin
      unique case (paddr)
        `RRS_IRQ_ENABLE_OFS: begin
          nxt_st.irq_en = st_ff.irq_en | (wbits & `RRS_IRQ_MASK);
        end
        `RRS_IRQ_DISABLE_OFS: begin
          nxt_st.irq_en = st_ff.irq_en & ~(wbits & `RRS_IRQ_MASK);
        end
        `RRS_MAXLEN_OFS: begin
          if (pstrb[0]) begin
            nxt_st.maxlen = pwdata[`RRS_LEN_W-1:0];
          end
        end
        default: begin
          nxt_st.irq_en = st_ff.irq_en;
        end
      endcase
    end

    // Coding indicator selecting the faster long range rate.
    if (ci_rpt.valid && ci_rpt.long_range && ci_rpt.rate_500k) begin
      nxt_st.rate_evt = 1'b1;
    end

    // A completed reception refreshes every status register; the match index only when dev_match is set.
    if (rx_res.done) begin
      nxt_st.crc_ok = rx_res.crc_ok;
      nxt_st.laddr = rx_res.laddr;
      nxt_st.crc = rx_res.crc;
      if (rx_res.dev_match) begin
        nxt_st.address_match_index = rx_res.dev_idx;
      end
      nxt_st.len_over = (rx_res.length > st_ff.maxlen);
      if (rx_res.long_range) begin
        nxt_st.rate = rx_res.rate_500k ? `RRS_RATE_500K : `RRS_RATE_125K;
      end else begin
        nxt_st.rate = `RRS_RATE_125K;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.irq_en <= `RRS_RESET_WORD;
      st_ff.maxlen <= `RRS_MAXLEN_RESET;
      st_ff.crc_ok <= 1'b0;
      st_ff.laddr <= 3'h0;
      st_ff.crc <= 24'h000000;
      st_ff.address_match_index <= 3'h0;
      st_ff.len_over <= 1'b0;
      st_ff.rate <= `RRS_RATE_125K;
      st_ff.rate_evt <= 1'b0;
      st_ff.prdata <= `RRS_RESET_WORD;
      st_ff.pslverr <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr && psel && penable;
  assign rate_switch_event = st_ff.rate_evt;
  assign irq_enable = st_ff.irq_en;
  assign max_payload_length = st_ff.maxlen;

endmodule

`default_nettype wire

// File: rrs_regs_properties.sv
// Concurrent checks on the ports of the receive status slice.
`timescale 1ns/100ps
`default_nettype none
module rrs_regs_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus, receive side and outputs
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire rrs_pkg::rrs_rx_res_t rx_res,
  input wire rrs_pkg::rrs_ci_t ci_rpt,
  input wire logic rate_switch_event,
  input wire logic [31:0] irq_enable,
  input wire logic [7:0] max_payload_length
);
  wire rs = psel && !penable && !pwrite;
  wire ws = psel && penable && pwrite;
  wire q = ci_rpt.valid && ci_rpt.long_range && ci_rpt.rate_500k;
  logic [2:0] la_ff, dai_ff;
  logic [23:0] crc_ff;
  logic [1:0] pay_ff;
  // Shadow copy of the last reception, used as the reference for reads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {la_ff, dai_ff, crc_ff, pay_ff} <= '0;
    end else if (rx_res.done) begin
      la_ff <= rx_res.laddr;
      crc_ff <= rx_res.crc;
      pay_ff <= {rx_res.long_range & rx_res.rate_500k, rx_res.length > max_payload_length};
      if (rx_res.dev_match) begin
        dai_ff <= rx_res.dev_idx;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_dis;
    ws && pstrb == 4'hF && paddr == 12'h308 |=> irq_enable == ($past(irq_enable) & ~$past(pwdata));
  endproperty
  property p_rd; rs && paddr == 12'h308 |=> prdata == $past(irq_enable); endproperty
  property p_rse; q |=> rate_switch_event; endproperty
  property p_rse0; rate_switch_event |-> $past(q); endproperty
  property p_ladr; rs && paddr == 12'h408 |=> prdata == {29'h0, $past(la_ff)}; endproperty
  property p_crc; rs && paddr == 12'h40C |=> prdata == {8'h0, $past(crc_ff)}; endproperty
  property p_dai; rs && paddr == 12'h410 |=> prdata == {29'h0, $past(dai_ff)}; endproperty
  property p_pay; rs && paddr == 12'h414 |=> prdata == {30'h0, $past(pay_ff)}; endproperty
  property p_ro;
    ws && paddr inside {12'h400, 12'h408, 12'h40C, 12'h410, 12'h414} |-> pslverr;
  endproperty
  a_dis: assert property (p_dis) else $error("enable not cleared by disable write");
  a_rd: assert property (p_rd) else $error("enable readback wrong");
  a_rse: assert property (p_rse) else $error("rate switch event missing");
  a_rse0: assert property (p_rse0) else $error("rate switch event without cause");
  a_ladr: assert property (p_ladr) else $error("logical address wrong");
  a_crc: assert property (p_crc) else $error("crc value wrong");
  a_dai: assert property (p_dai) else $error("match index wrong");
  a_pay: assert property (p_pay) else $error("payload status wrong");
  a_ro: assert property (p_ro) else $error("status write not refused");
  c_boost: cover property (rate_switch_event);
  c_err: cover property (pslverr);
  c_match: cover property (rx_res.done && rx_res.dev_match);
endmodule
bind rrs_regs rrs_regs_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .rx_res(rx_res), .ci_rpt(ci_rpt),
  .rate_switch_event(rate_switch_event), .irq_enable(irq_enable),
  .max_payload_length(max_payload_length));
`default_nettype wire

// File: tb.sv
// Self-checking bench of the receive status slice.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, irq_enable;
  logic pready, pslverr, rate_switch_event;
  logic [7:0] max_payload_length;
  rrs_pkg::rrs_rx_res_t rx_res;
  rrs_pkg::rrs_ci_t ci_rpt;
  int n_mismatch, n_compared, cyc;
  int bits[6] = '{20, 21, 22, 23, 27, 28};
  logic [11:0] ra[7] = '{12'h304, 12'h308, 12'h400, 12'h408, 12'h40C, 12'h410, 12'h414};
  rrs_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_res(rx_res), .ci_rpt(ci_rpt),
    .rate_switch_event(rate_switch_event), .irq_enable(irq_enable),
    .max_payload_length(max_payload_length));
  rrs_air_model u_air (.pclk(pclk), .rx_res(rx_res), .ci_rpt(ci_rpt));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic stop_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic rx(input logic [42:0] r, input logic [31:0] address_match_index, input logic [31:0] pay);
    u_air.send(r);
    xfer(1'h0, 12'h400, 32'h0);
    chk("crc status", q, {31'h0, r[41]});
    xfer(1'h0, 12'h408, 32'h0);
    chk("laddr", q, {29'h0, r[40:38]});
    xfer(1'h0, 12'h40C, 32'h0);
    chk("crc", q, {8'h0, r[37:14]});
    xfer(1'h0, 12'h410, 32'h0);
    chk("index", q, address_match_index);
    xfer(1'h0, 12'h414, 32'h0);
    chk("payload", q, pay);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ra[i]) begin
      xfer(1'h0, ra[i], 32'h0);
      chk("reset", q, 32'h0);
    end
    xfer(1'h0, 12'h518, 32'h0);
    chk("maxlen reset", q, 32'hFF);
    foreach (bits[i]) begin
      xfer(1'h1, 12'h304, 32'hFFFFFFFF);
      xfer(1'h1, 12'h308, 32'h1 << bits[i]);
      xfer(1'h0, 12'h308, 32'h0);
      chk("enable", q, 32'h18F00000 ^ (32'h1 << bits[i]));
      chk("enable port", irq_enable, 32'h18F00000 ^ (32'h1 << bits[i]));
    end
    xfer(1'h1, 12'h518, 32'h20);
    xfer(1'h0, 12'h518, 32'h0);
    chk("maxlen", q, 32'h20);
    chk("maxlen port", max_payload_length, 32'h20);
    for (int i = 1; i < 4; i++) begin
      u_air.boost(i[1], i[0]);
      #1 chk("boost", rate_switch_event, i == 3);
      @(posedge pclk);
      #1 chk("boost end", rate_switch_event, 32'h0);
    end
    rx({1'h1, 1'h1, 3'h5, 24'hA5C33C, 1'h1, 3'h6, 8'h21, 1'h1, 1'h1}, 32'h6, 32'h3);
    rx({1'h1, 1'h0, 3'h2, 24'h5A0FF0, 1'h0, 3'h1, 8'h20, 1'h0, 1'h1}, 32'h6, 32'h0);
    xfer(1'h1, 12'h40C, 32'hFFFFFFFF);
    chk("status write error", e, 32'h1);
    xfer(1'h0, 12'h40C, 32'h0);
    chk("status kept", q, 32'h005A0FF0);
    xfer(1'h0, 12'h000, 32'h0);
    chk("unmapped error", e, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
